//--- logic/i2cmt_pkg.sv
// Purpose: Shared constants and types of the I2C master transmit and event block
// Assumes: 200 MHz core clock, APB register access, one word per register
// Notes:   Bit positions follow the control and status byte layouts
package i2cmt_pkg;

  // Register byte addresses
  localparam logic [7:0] I2CMT_OFF_CTRL = 8'h00;
  localparam logic [7:0] I2CMT_OFF_SR1  = 8'h04;
  localparam logic [7:0] I2CMT_OFF_SR2  = 8'h08;
  localparam logic [7:0] I2CMT_OFF_DATA = 8'h0c;

  // Control byte fields
  localparam int unsigned I2CMT_CR_PE    = 5;
  localparam int unsigned I2CMT_CR_GENERAL_CALL_ENABLE  = 4;
  localparam int unsigned I2CMT_CR_START = 3;
  localparam int unsigned I2CMT_CR_ACK   = 2;
  localparam int unsigned I2CMT_CR_STOP  = 1;
  localparam int unsigned I2CMT_CR_ITE   = 0;
  localparam logic [7:0]  I2CMT_CTRL_RST = 8'h00;
  localparam logic [7:0]  I2CMT_BYTE_RST = 8'h00;

  // Byte framing
  localparam logic [2:0]  I2CMT_BIT_MSB  = 3'h7;
  localparam logic [2:0]  I2CMT_BIT_LSB  = 3'h0;
  localparam logic [3:0]  I2CMT_POS_LAST = 4'h9;
  localparam logic [3:0]  I2CMT_POS_ZERO = 4'h0;
  localparam logic [3:0]  I2CMT_POS_FIRST = 4'h1;
  localparam logic [4:0]  I2CMT_HDR10    = 5'h1e;

  // Address phase of a master transfer
  localparam logic [1:0]  I2CMT_PH_ADDR1 = 2'h0;
  localparam logic [1:0]  I2CMT_PH_ADDR2 = 2'h1;
  localparam logic [1:0]  I2CMT_PH_DATA  = 2'h2;

  // Timing: quarter of an SCL period in core cycles
  localparam int unsigned I2CMT_CLK_PERIOD_PS = 5000;
  localparam int unsigned I2CMT_SCL_PERIOD_NS = 10000;
  localparam int unsigned I2CMT_QTR_CYC =
    (I2CMT_SCL_PERIOD_NS * 1000) / (4 * I2CMT_CLK_PERIOD_PS);
  localparam int unsigned I2CMT_DIV_W = 12;

  // Master sequencer states
  typedef enum logic [12:0] {
    I2CMT_S_IDLE  = 13'h0001,
    I2CMT_S_START = 13'h0002,
    I2CMT_S_HOLD  = 13'h0004,
    I2CMT_S_BLO   = 13'h0008,
    I2CMT_S_BHI   = 13'h0010,
    I2CMT_S_ALO   = 13'h0020,
    I2CMT_S_AHI   = 13'h0040,
    I2CMT_S_NACK  = 13'h0080,
    I2CMT_S_RS    = 13'h0100,
    I2CMT_S_PLO   = 13'h0200,
    I2CMT_S_PHI   = 13'h0400,
    I2CMT_S_PEND  = 13'h0800,
    I2CMT_S_ERR   = 13'h1000
  } i2cmt_state_t;

endpackage : i2cmt_pkg

//--- logic/i2cmt_line_sync.sv
// Purpose: Synchronise SCL and SDA and find edges and bus conditions
// Assumes: Pins are asynchronous to clk_in
// Notes:   First flop of each chain feeds only the second flop
`timescale 1ns/1ps
module i2cmt_line_sync
  import i2cmt_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out,
  output logic      scl_rise_out,
  output logic      start_out,
  output logic      stop_out
);

  logic [1:0] scl_meta_q;
  logic [1:0] sda_meta_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  // Two-flop chains, idle bus reads high
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_meta_q <= {scl_meta_q[0], scl_in};
      sda_meta_q <= {sda_meta_q[0], sda_in};
      scl_prev_q <= scl_meta_q[1];
      sda_prev_q <= sda_meta_q[1];
    end
  end

  // Conditions: SDA moves while SCL stays high
  assign scl_out      = scl_meta_q[1];
  assign sda_out      = sda_meta_q[1];
  assign scl_rise_out = scl_meta_q[1] & ~scl_prev_q;
  assign start_out    = scl_meta_q[1] & scl_prev_q & sda_prev_q & ~sda_meta_q[1];
  assign stop_out     = scl_meta_q[1] & scl_prev_q & ~sda_prev_q & sda_meta_q[1];

endmodule : i2cmt_line_sync

//--- logic/i2cmt_top.sv
// Purpose: I2C master transmitter, stop generation, error and event flags, control byte
// Assumes: APB slave with zero wait states; halt and core mask come from the core clock
// Notes:   Address matching and receive sequencing live elsewhere; matching reports via inputs
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module i2cmt_top
  import i2cmt_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = I2CMT_QTR_CYC
)
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        addr_match_in,
  input  wire logic        gc_match_in,
  input  wire logic        halt_in,
  input  wire logic        core_irq_masked_in,
  output logic             irq_out,
  output logic             alt_func_out
);

  i2cmt_state_t st_q, st_d;
  logic [7:0]  ctrl_q, data_q, shift_q;
  logic [2:0]  bit_q;
  logic [3:0]  pos_q;
  logic [1:0]  aph_q;
  logic [I2CMT_DIV_W-1:0] div_q;
  logic        ph_q, hdr_q, dr_full_q, sr1_seen_q, supp_q, busy_q, ms_q;
  logic        sb_q, header_sent_flag_q, btf_q, tra_q, addr_matched_flag_q, ev6_q, af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, general_call_seen_q;
  logic        scl_oe_q, sda_oe_q, irq_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic        scl_s, sda_s, scl_rise, start_det, stop_det;
  logic        ev_sb, ev_af, ev_arbitration_lost_flag, ev_ack, ev_done;

  i2cmt_line_sync u_sync (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .scl_out      (scl_s),
    .sda_out      (sda_s),
    .scl_rise_out (scl_rise),
    .start_out    (start_det),
    .stop_out     (stop_det)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // APB decode; registers frozen in halt
  wire run     = ~halt_in;
  wire setup   = psel_in & ~penable_in;
  wire acc     = psel_in & penable_in & run;
  wire wr      = acc & pwrite_in;
  wire rd      = acc & ~pwrite_in;
  wire cr_wr   = wr & hit(paddr_in, I2CMT_OFF_CTRL);
  wire dr_wr   = wr & hit(paddr_in, I2CMT_OFF_DATA);
  wire dr_rd   = rd & hit(paddr_in, I2CMT_OFF_DATA);
  wire sr1_rd  = rd & hit(paddr_in, I2CMT_OFF_SR1);
  wire sr2_rd  = rd & hit(paddr_in, I2CMT_OFF_SR2);
  wire mapped  = hit(paddr_in, I2CMT_OFF_CTRL) | hit(paddr_in, I2CMT_OFF_SR1) |
                 hit(paddr_in, I2CMT_OFF_SR2) | hit(paddr_in, I2CMT_OFF_DATA);
  wire pe      = ctrl_q[I2CMT_CR_PE];
  wire start_b = ctrl_q[I2CMT_CR_START];
  wire stop_b  = ctrl_q[I2CMT_CR_STOP];
  wire irq_enable     = ctrl_q[I2CMT_CR_ITE];
  // Enable after this write; an enabling write must survive the disable clear
  wire       pe_drop   = cr_wr ? ~pwdata_in[I2CMT_CR_PE] : ~pe;
  // Only a disabling write from the enabled state may change stop
  wire [7:0] stop_keep = ((cr_wr && pe) ? pwdata_in[7:0] : ctrl_q) & (8'h01 << I2CMT_CR_STOP);

  // Event summary and hold sources
  wire event_flag      = sb_q | header_sent_flag_q | btf_q | addr_matched_flag_q | ev6_q | af_q | stop_detected_flag_q | arbitration_lost_flag_q | bus_error_flag_q;
  wire hold_f   = sb_q | header_sent_flag_q | btf_q | ev6_q;
  wire [7:0] sr1_v = {event_flag, header_sent_flag_q, tra_q, busy_q, btf_q, addr_matched_flag_q, ms_q, sb_q};
  wire [7:0] sr2_v = {3'h0, af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, general_call_seen_q};
  wire [7:0] rmux  = hit(paddr_in, I2CMT_OFF_CTRL) ? ctrl_q :
                     hit(paddr_in, I2CMT_OFF_SR1)  ? sr1_v  :
                     hit(paddr_in, I2CMT_OFF_SR2)  ? sr2_v  :
                     hit(paddr_in, I2CMT_OFF_DATA) ? data_q : I2CMT_BYTE_RST;

  // Quarter-period tick; high phases wait for SCL really high
  wire qtick    = (div_q == I2CMT_DIV_W'(QTR_CYCLES - 1));
  wire hi_st    = (st_q == I2CMT_S_BHI) | (st_q == I2CMT_S_AHI) | (st_q == I2CMT_S_PHI);
  wire adv      = qtick & ph_q & (~hi_st | scl_s);
  wire own_cond = (st_q == I2CMT_S_START) | (st_q == I2CMT_S_RS) | (st_q == I2CMT_S_PLO) |
                  (st_q == I2CMT_S_PHI) | (st_q == I2CMT_S_PEND);
  wire misplace = (start_det | stop_det) & busy_q & ~own_cond & (pos_q != I2CMT_POS_ZERO);
  // first pulse of the 9-bit frame, no bus error
  wire first_pl = misplace & (pos_q == I2CMT_POS_FIRST) & scl_s;
  // later in the byte it is a bus error
  wire ev_bus_error_flag  = misplace & ~first_pl;
  // Header flag latched at load; by the time of the ack the shifter holds only the last data bit
  wire hdr_byte = hdr_q;
  wire stop_rel = cr_wr & ~pwdata_in[I2CMT_CR_STOP] & stop_b & btf_q & ~ms_q;

  // Master sequencer next state
  always_comb
  begin
    st_d    = st_q;
    ev_sb   = 1'b0;
    ev_af   = 1'b0;
    ev_arbitration_lost_flag = 1'b0;
    ev_ack  = 1'b0;
    ev_done = 1'b0;
    case (st_q)
      I2CMT_S_IDLE:
        // start from slave mode once bus free
        if (start_b && !busy_q) st_d = I2CMT_S_START;
      I2CMT_S_START:
        if (adv)
        begin
          st_d  = I2CMT_S_HOLD;
          ev_sb = 1'b1;
        end
      I2CMT_S_HOLD:
        // stop after the current start or byte
        if (stop_b) st_d = I2CMT_S_PLO;
        else if (start_b) st_d = I2CMT_S_RS;
        else if (!hold_f && dr_full_q) st_d = I2CMT_S_BLO;
      I2CMT_S_BLO:
        if (adv) st_d = I2CMT_S_BHI;
      I2CMT_S_BHI:
        if (adv)
        begin
          // released one but bus shows zero
          if (shift_q[7] && !sda_s)
          begin
            ev_arbitration_lost_flag = 1'b1;
            st_d    = I2CMT_S_IDLE;
          end
          else if (bit_q == I2CMT_BIT_LSB) st_d = I2CMT_S_ALO;
          else st_d = I2CMT_S_BLO;
        end
      I2CMT_S_ALO:
        if (adv) st_d = I2CMT_S_AHI;
      I2CMT_S_AHI:
      begin
        // nack keeps re-setting the flag during the ninth pulse
        ev_af = qtick & scl_s & sda_s;
        if (adv)
        begin
          ev_ack = ~sda_s;
          st_d   = sda_s ? I2CMT_S_NACK : (stop_b ? I2CMT_S_PLO : I2CMT_S_HOLD);
        end
      end
      I2CMT_S_NACK, I2CMT_S_ERR:
        // software resumes with start or stop
        if (stop_b) st_d = I2CMT_S_PLO;
        else if (start_b) st_d = I2CMT_S_RS;
      I2CMT_S_RS:
        if (adv) st_d = I2CMT_S_START;
      I2CMT_S_PLO:
        if (adv) st_d = I2CMT_S_PHI;
      I2CMT_S_PHI:
        if (adv) st_d = I2CMT_S_PEND;
      I2CMT_S_PEND:
        if (adv)
        begin
          st_d    = I2CMT_S_IDLE;
          ev_done = 1'b1;
        end
      default:
        st_d = I2CMT_S_IDLE;
    endcase
    // error leaves clock free, data line as it was
    if (ev_bus_error_flag && ms_q) st_d = I2CMT_S_ERR;
    if (!pe) st_d = I2CMT_S_IDLE;
  end

  // clock held low in hold state and for slave match
  wire scl_pull = (st_q == I2CMT_S_HOLD) | (st_q == I2CMT_S_BLO) | (st_q == I2CMT_S_ALO) |
                  (st_q == I2CMT_S_PLO) | (~ms_q & addr_matched_flag_q);
  wire sda_pull = (st_q == I2CMT_S_START) | (st_q == I2CMT_S_PLO) | (st_q == I2CMT_S_PHI) |
                  (((st_q == I2CMT_S_BLO) | (st_q == I2CMT_S_BHI)) & ~shift_q[7]) |
                  (((st_q == I2CMT_S_HOLD) | (st_q == I2CMT_S_ERR)) & sda_oe_q);

  // Divider, phase and state
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_q <= '0;
      ph_q  <= 1'b0;
      st_q  <= I2CMT_S_IDLE;
    end
    else if (run)
    begin
      div_q <= qtick ? '0 : div_q + 1'b1;
      ph_q  <= (st_d != st_q) ? 1'b0 : (ph_q ^ (qtick & (~hi_st | scl_s)));
      st_q  <= st_d;
    end
  end

  // load byte from data register, shift out MSB first
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shift_q <= I2CMT_BYTE_RST;
      bit_q   <= I2CMT_BIT_MSB;
      hdr_q   <= 1'b0;
    end
    else if (run && st_q == I2CMT_S_HOLD && st_d == I2CMT_S_BLO)
    begin
      shift_q <= data_q;
      bit_q   <= I2CMT_BIT_MSB;
      hdr_q   <= (data_q[7:3] == I2CMT_HDR10);
    end
    else if (run && st_q == I2CMT_S_BHI && st_d == I2CMT_S_BLO)
    begin
      shift_q <= {shift_q[6:0], 1'b0};
      bit_q   <= bit_q - 1'b1;
    end
  end

  // Bus monitor: busy and pulse position in the 9-bit frame
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      busy_q <= 1'b0;
      pos_q  <= I2CMT_POS_ZERO;
    end
    else if (run)
    begin
      if (start_det | stop_det) pos_q <= I2CMT_POS_ZERO;
      else if (scl_rise && busy_q)
        pos_q <= (pos_q == I2CMT_POS_LAST) ? I2CMT_POS_FIRST : pos_q + 1'b1;
      // busy drops on a misplaced condition, for software to poll
      if (stop_det | misplace | ~pe) busy_q <= 1'b0;
      else if (start_det) busy_q <= 1'b1;
    end
  end

  // Control byte
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in) ctrl_q <= I2CMT_CTRL_RST;
    else if (run)
    begin
      if (cr_wr)
      begin
        // first write with enable set takes only the enable
        if (!pe) ctrl_q[I2CMT_CR_PE] <= pwdata_in[I2CMT_CR_PE];
        else ctrl_q[5:0] <= pwdata_in[5:0];
      end
      if (ev_sb) ctrl_q[I2CMT_CR_START] <= 1'b0;
      // disabled clears all but stop; general call too
      if (pe_drop) ctrl_q <= stop_keep;
      // master clears stop after the stop is sent
      if (ev_done && ms_q) ctrl_q[I2CMT_CR_STOP] <= 1'b0;
      ctrl_q[7:6] <= 2'h0;
    end
  end

  // Data register and clearing-sequence tracking
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      data_q     <= I2CMT_BYTE_RST;
      dr_full_q  <= 1'b0;
      sr1_seen_q <= 1'b0;
      supp_q     <= 1'b0;
    end
    else if (run)
    begin
      if (dr_wr) data_q <= pwdata_in[7:0];
      if (st_q == I2CMT_S_HOLD && st_d == I2CMT_S_BLO) dr_full_q <= 1'b0;
      else if (dr_wr) dr_full_q <= 1'b1;
      if (dr_wr | dr_rd | cr_wr) sr1_seen_q <= 1'b0;
      if (sr1_rd) sr1_seen_q <= 1'b1;
      // stop pulse release hides the next stop event
      if (stop_det) supp_q <= 1'b0;
      if (stop_rel) supp_q <= 1'b1;
      if (!pe)
      begin
        dr_full_q  <= 1'b0;
        sr1_seen_q <= 1'b0;
      end
    end
  end

  // Master mode and address phase
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ms_q  <= 1'b0;
      aph_q <= I2CMT_PH_ADDR1;
    end
    else if (run)
    begin
      if (st_q == I2CMT_S_START) aph_q <= I2CMT_PH_ADDR1;
      else if (ev_ack && aph_q != I2CMT_PH_DATA)
        aph_q <= (aph_q == I2CMT_PH_ADDR1 && hdr_byte) ? I2CMT_PH_ADDR2 : I2CMT_PH_DATA;
      // stop on the bus, or loss, returns to slave
      if (!pe || ev_arbitration_lost_flag || ev_done || (stop_det && !own_cond)) ms_q <= 1'b0;
      else if (st_q == I2CMT_S_START) ms_q <= 1'b1;
    end
  end

  // Event flags: clears first, then sets so an event wins; disable clears all last
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      {sb_q, header_sent_flag_q, btf_q, tra_q, addr_matched_flag_q, ev6_q, af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, general_call_seen_q} <= '0;
    else if (run)
    begin
      // start and header flags need status one then address write
      if (sr1_seen_q && dr_wr) {sb_q, header_sent_flag_q} <= 2'h0;
      // byte flag cleared by status one then matching data access
      if (sr1_seen_q && (tra_q ? dr_wr : dr_rd) || stop_rel) {btf_q, tra_q} <= 2'h0;
      // address-complete cleared by status one then control write
      if (sr1_seen_q && cr_wr) ev6_q <= 1'b0;
      if (sr1_rd) addr_matched_flag_q <= 1'b0;
      // slave nack failure cleared by status one read
      if (sr1_rd && !ms_q) af_q <= 1'b0;
      // status two read clears the error and stop flags
      if (sr2_rd) {af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q} <= 4'h0;
      if (stop_det) general_call_seen_q <= 1'b0;
      if (ev_arbitration_lost_flag || (stop_det && !own_cond)) tra_q <= 1'b0;
      if (ev_sb) sb_q <= 1'b1;
      if (ev_ack && aph_q == I2CMT_PH_ADDR1 && hdr_byte) header_sent_flag_q <= 1'b1;
      if (ev_ack && (aph_q == I2CMT_PH_ADDR2 || (aph_q == I2CMT_PH_ADDR1 && !hdr_byte))) ev6_q <= 1'b1;
      if (ev_ack && aph_q == I2CMT_PH_DATA) {btf_q, tra_q} <= 2'h3;
      if (ev_af) af_q <= 1'b1;
      if (ev_arbitration_lost_flag) arbitration_lost_flag_q <= 1'b1;
      if (ev_bus_error_flag) bus_error_flag_q <= 1'b1;
      if (addr_match_in && !ms_q) addr_matched_flag_q <= 1'b1;
      if (gc_match_in && ctrl_q[I2CMT_CR_GENERAL_CALL_ENABLE]) general_call_seen_q <= 1'b1;
      if (stop_det && !ms_q && !own_cond && busy_q && !supp_q) stop_detected_flag_q <= 1'b1;
      if (!pe)
        {sb_q, header_sent_flag_q, btf_q, tra_q, addr_matched_flag_q, ev6_q, af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, general_call_seen_q} <= '0;
    end
  end

  // Registered outputs: pins, interrupt, APB answer
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      {scl_oe_q, sda_oe_q, irq_q, pready_q, pslverr_q} <= 5'h0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= 1'b1;
      if (run)
      begin
        scl_oe_q <= pe & scl_pull;
        sda_oe_q <= pe & sda_pull;
      end
      // one line, enable bit and core mask; wakes from wait only
      irq_q <= run & irq_enable & ~core_irq_masked_in & event_flag;
      if (setup)
      begin
        prdata_q  <= {24'h0, rmux};
        pslverr_q <= ~mapped;
      end
    end
  end

  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe_out   = scl_oe_q;
  assign sda_oe_out   = sda_oe_q;
  assign irq_out      = irq_q;
  assign prdata_out   = prdata_q;
  assign pready_out   = pready_q;
  assign pslverr_out  = pslverr_q;
  assign alt_func_out = pe;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_first_enable: assert property (cr_wr && !pe |=> ctrl_q[4:0] == 5'h0 || $past(ctrl_q[4:0]) != 5'h0)
    else $error("first enable write took more than enable");
  a_disable_clear: assert property (!pe && !halt_in |=> !ms_q && !sb_q && !btf_q && !ctrl_q[I2CMT_CR_ITE])
    else $error("disabled block kept flags");
  a_hold_scl: assert property (st_q == I2CMT_S_HOLD && pe && run ##1 run |-> scl_oe_q)
    else $error("clock not stretched in hold");
  a_bus_error_flag_event: assert property (ev_bus_error_flag && pe && run |=> bus_error_flag_q && event_flag)
    else $error("bus error not flagged");
  a_first_pulse: assert property (first_pl && run |=> !busy_q && !$rose(bus_error_flag_q))
    else $error("first pulse condition mishandled");
  a_arbitration_lost_flag_slave: assert property (ev_arbitration_lost_flag && pe && run |=> arbitration_lost_flag_q && !ms_q)
    else $error("arbitration loss kept master");
  a_start_clear: assert property ($rose(sb_q) |-> !start_b)
    else $error("start bit survived start");
  a_stop_master: assert property (ev_done && ms_q && run |=> !stop_b && !ms_q)
    else $error("stop bit not cleared after stop");
  a_nack_flag: assert property (ev_af && pe && run |=> af_q && event_flag)
    else $error("nack not flagged");
  a_irq_gate: assert property (irq_out |-> $past(irq_enable && !core_irq_masked_in && !halt_in))
    else $error("interrupt not gated");
  a_halt_freeze: assert property (halt_in |=> $stable(ctrl_q) && $stable(st_q))
    else $error("registers moved in halt");

endmodule : i2cmt_top

//--- sim/i2cmt_slave_model.sv
// Purpose: Behavioural I2C slave that acks or nacks each byte and reports it
// Assumes: Lines are resolved outside with pull-ups
// Notes:   Never stretches SCL, so the master sets the pace
`timescale 1ns/1ps
module i2cmt_slave_model (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       nack_in,
  output logic            sda_oe_out,
  output logic [7:0]      byte_out,
  output logic            byte_stb_out
);
  int         cnt;
  logic [7:0] shift_q;
  initial
  begin
    cnt = 0;
    sda_oe_out = 0;
    byte_out = 8'h00;
    byte_stb_out = 0;
  end
  // Start condition restarts framing; SCL looked at 1 ns late so a
  // data change in the step where SCL falls is not taken for a start
  always @(negedge sda_in)
  begin
    #1;
    if (scl_in) cnt = 0;
  end
  // Bits MSB first, sampled on rising SCL
  always @(posedge scl_in)
  begin
    if (cnt < 8) shift_q = {shift_q[6:0], sda_in};
    cnt = cnt + 1;
    if (cnt == 8) byte_out = shift_q;
    byte_stb_out = (cnt == 8);
  end
  // ack or nack on ninth pulse
  always @(negedge scl_in)
  begin
    sda_oe_out = (cnt == 8) && !nack_in;
    if (cnt == 9) cnt = 0;
  end
endmodule : i2cmt_slave_model

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the master transmitter and control byte
// Assumes: Zero wait APB, QTR_CYCLES shortened to 4
// Notes:   Bytes seen by the slave model are compared with a queue
`timescale 1ns/1ps
module tb_top
  import i2cmt_pkg::*;
;
  logic clk_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [7:0]  paddr = 8'h00, a;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, scl_oe, sda_oe, slv_oe, nack = 0, irq, alt, stb, mask = 0, halt = 0;
  logic [7:0]  sbyte;
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | slv_oe);
  int err_count = 0, total_checks = 0, dummy;
  logic [7:0]  exp_q[$];
  always #2.5 clk_in = ~clk_in;
  i2cmt_top #(.QTR_CYCLES(4)) u_i2cmt_top (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .addr_match_in(1'b0), .gc_match_in(1'b0),
    .halt_in(halt), .core_irq_masked_in(mask), .irq_out(irq), .alt_func_out(alt));
  i2cmt_slave_model u_i2cmt_slave_model (.scl_in(scl_w), .sda_in(sda_w), .nack_in(nack),
    .sda_oe_out(slv_oe), .byte_out(sbyte), .byte_stb_out(stb));
  task automatic summarize;
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk_in);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata; perr = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50)
    begin
      err_count++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d}, r);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0, r);
  endtask : rd
  task automatic poll(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do
    begin
      rd(ad);
      n++;
    end while ((r[7:0] & m) !== v && n < 3000);
    if (n >= 3000)
    begin
      err_count++;
      summarize();
    end
  endtask : poll
  // Every byte on the wire must match what software wrote
  always @(posedge stb) chk({24'h0, sbyte}, {24'h0, exp_q.pop_front()});
  initial
  begin
    dummy = $urandom(96686);
    repeat (8) @(posedge clk_in);
    resetn_in <= 1;
    rd(I2CMT_OFF_CTRL); chk(r, 32'h0);
    rd(I2CMT_OFF_SR2); chk(r, 32'h0);
    rd(8'h10); chk({31'h0, perr}, 32'h1);
    wr(I2CMT_OFF_CTRL, 8'h25); rd(I2CMT_OFF_CTRL); chk(r, 32'h20);
    wr(I2CMT_OFF_CTRL, 8'he5); rd(I2CMT_OFF_CTRL); chk(r, 32'h25);
    // Two transfers: acked bytes, then a nacked address
    for (int t = 0; t < 2; t++)
    begin
      nack <= (t == 1);
      poll(I2CMT_OFF_SR1, 8'h10, 8'h00);
      wr(I2CMT_OFF_CTRL, 8'h2d);
      poll(I2CMT_OFF_SR1, 8'h83, 8'h83);
      rd(I2CMT_OFF_CTRL); chk(r & 32'h8, 32'h0);
      chk({31'h0, irq}, 32'h1);
      mask <= 1;
      repeat (3) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      mask <= 0;
      a = 8'($urandom % 128) << 1;
      exp_q.push_back(a);
      wr(I2CMT_OFF_DATA, a);
      if (t == 0)
      begin
        poll(I2CMT_OFF_SR1, 8'h81, 8'h80);
        wr(I2CMT_OFF_CTRL, 8'h25);
        for (int b = 0; b < 3; b++)
        begin
          a = 8'($urandom);
          exp_q.push_back(a);
          rd(I2CMT_OFF_SR1);
          wr(I2CMT_OFF_DATA, a);
          if (b < 2) poll(I2CMT_OFF_SR1, 8'h88, 8'h88);
        end
      end
      else
      begin
        poll(I2CMT_OFF_SR2, 8'h10, 8'h10);
        chk({31'h0, scl_oe}, 32'h0);
      end
      wr(I2CMT_OFF_CTRL, 8'h27);
      poll(I2CMT_OFF_SR1, 8'h02, 8'h00);
      rd(I2CMT_OFF_CTRL); chk(r & 32'h2, 32'h0);
      chk({30'h0, scl_oe, sda_oe}, 32'h0);
    end
    // Halt freezes the control byte, the write is lost
    halt <= 1;
    wr(I2CMT_OFF_CTRL, 8'h3f);
    halt <= 0;
    rd(I2CMT_OFF_CTRL);
    chk(r, 32'h25);
    // Disable keeps only the stop bit
    wr(I2CMT_OFF_CTRL, 8'h02); rd(I2CMT_OFF_CTRL); chk(r, 32'h2);
    chk({31'h0, alt}, 32'h0);
    chk(exp_q.size(), 32'h0);
    summarize();
  end
endmodule : tb_top
